// ===== rtl/hmpc_top.sv
// Notes on behaviour
// - halt with autowake off: plain Halt if osc irq enable clear, else Active-halt
// - halt with autowake on and osc irq enable clear enters autowake halt
// - leaving Halt starts oscillator at once, waits 256 or 4096 cycles
// - entering Halt or autowake halt forces level bits to 10b
// - entering Active-halt clears level bits; pending interrupt wakes at once
// - plain Halt stops main oscillator, cpu and peripheral clocks
// - watchdog option may turn halt into a watchdog reset
// - Active-halt exits on rtc, halt-capable irq or reset; reset adds delay
// - Active-halt keeps only main oscillator and rtc counter clocked
// - Active-halt never yields a watchdog reset on halt
// - autowake delay counts rc clock through fixed divider and prescaler
// - delay expiry sets flag, raises irq, restarts oscillator with delay
// - reading autowake status clears flag and its interrupt
// - measure bit in run enables rc oscillator, routes it to timer capture
// - autowake halt exits on reset, autowake irq or halt-capable irq
// - before service push condition codes, load level bits with priority
// - opcode 8Eh is the halt instruction
// - fixed divider ahead of the prescaler divides by 64
// - prescaler is 8 bits, resets FFh, 00h write ignored
`timescale 1ns/1ps
`include "hmpc_regs.svh"

module hmpc_top (
	input  wire logic                     ref_clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     instr_valid_i,
	input  wire logic [7:0]               opcode_i,
	input  wire logic                     osc_interrupt_enable_i,
	input  wire logic                     autowake_enable_i,
	input  wire logic                     autowake_measure_i,
	input  wire logic                     autowake_ctrl_status_rd_i,
	input  wire logic                     autowake_prescaler_wr_i,
	input  wire logic [7:0]               autowake_prescaler_wdata_i,
	input  wire logic                     watchdog_enabled_i,
	input  wire logic                     watchdog_halt_option_i,
	input  wire logic                     long_delay_option_i,
	input  wire logic                     irq_halt_capable_i,
	input  wire logic                     irq_other_i,
	input  wire logic                     rtc_irq_i,
	input  wire logic [1:0]               irq_priority_i,
	input  wire logic                     cc_pop_i,
	input  wire logic [1:0]               cc_pop_level_i,
	input  wire logic                     wake_rc_clock_i,
	output hmpc_pkg::hmpc_clk_en_type     clk_en_o,
	output hmpc_pkg::hmpc_state_type      mode_o,
	output logic [1:0]                    interrupt_level_bits_o,
	output logic                          cc_push_o,
	output logic                          service_irq_o,
	output logic                          fetch_reset_vector_o,
	output logic                          watchdog_reset_o,
	output logic                          autowake_irq_o,
	output logic [7:0]                    autowake_ctrl_status_o,
	output logic [7:0]                    autowake_prescaler_o,
	output logic                          timer_capture_input_two_o
);
	import hmpc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		hmpc_state_type  st;
		hmpc_cause_type  cause;
		logic            awu_flag;
		logic [7:0]      presc;
		logic [1:0]      ilb;
		hmpc_clk_en_type clk;
		logic            push;
		logic            svc;
		logic            fetch;
		logic            wdg_rst;
		logic            stab_start;
		logic            tcap;
		logic            rc_s1;
		logic            rc_s2;
		logic            rc_s3;
		logic [7:0]      csr;
	} hmpc_top_type;

	localparam hmpc_clk_en_type CLK_RUN  = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	localparam hmpc_clk_en_type CLK_OFF  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	localparam hmpc_clk_en_type CLK_STAB = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

	hmpc_top_type r;
	hmpc_top_type next_r;
	logic         stab_done;
	logic         awu_done;
	logic         rc_tick;
	logic         halt_op;

	// ----------------------------------------
	// helper timers
	// ----------------------------------------
	hmpc_stab_timer u_stab (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.start_i   (r.stab_start),
		.long_i    (long_delay_option_i),
		.done_o    (stab_done)
	);

	// prescaler 00h never reaches the chain
	hmpc_awu_timer u_awu (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.run_i     (r.st == ST_AWU),
		.rc_tick_i (rc_tick),
		.presc_i   (r.presc),
		.done_o    (awu_done)
	);

	assign rc_tick = r.rc_s2 & ~r.rc_s3;
	assign halt_op = instr_valid_i && (opcode_i == `HMPC_HALT_OPCODE);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_r            = r;
		next_r.push       = 1'b0;
		next_r.svc        = 1'b0;
		next_r.fetch      = 1'b0;
		next_r.wdg_rst    = 1'b0;
		next_r.stab_start = 1'b0;
		// second and third stages form the rc edge detect; the second also feeds capture
		next_r.rc_s1      = wake_rc_clock_i;
		next_r.rc_s2      = r.rc_s1;
		next_r.rc_s3      = r.rc_s2;

		// 00h leaves the prescaler unchanged
		if (autowake_prescaler_wr_i && autowake_prescaler_wdata_i != `HMPC_PRESC_FORBID)
			next_r.presc = autowake_prescaler_wdata_i;

		// flag set beats the read clear in the same cycle
		if (awu_done)
			next_r.awu_flag = 1'b1;
		else if (autowake_ctrl_status_rd_i)
			next_r.awu_flag = 1'b0;

		if (cc_pop_i)
			next_r.ilb = cc_pop_level_i;

		case (r.st)
			ST_RUN:
			begin
				next_r.clk         = CLK_RUN;
				next_r.clk.wake_rc = autowake_measure_i;
				if (halt_op)
				begin
					if (osc_interrupt_enable_i)
					begin
						// rtc bounds the stay, so no watchdog reset here
						next_r.st  = ST_ACTIVE;
						next_r.ilb = `HMPC_ILB_ACTIVE;
						next_r.clk = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
					end
					else if (watchdog_enabled_i && !watchdog_halt_option_i)
						next_r.wdg_rst = 1'b1;
					else if (autowake_enable_i)
					begin
						next_r.st  = ST_AWU;
						next_r.ilb = `HMPC_ILB_HALT;
						next_r.clk = CLK_OFF;
						next_r.clk.wake_rc = 1'b1;
					end
					else
					begin
						next_r.st  = ST_HALT;
						next_r.ilb = `HMPC_ILB_HALT;
						next_r.clk = CLK_OFF;
					end
				end
			end
			ST_HALT, ST_AWU:
			begin
				// other sources stay pending and do not wake
				if (irq_halt_capable_i || awu_done)
				begin
					next_r.st         = ST_STAB;
					next_r.cause      = WK_IRQ;
					next_r.stab_start = 1'b1;
					next_r.clk        = CLK_STAB;
				end
			end
			ST_ACTIVE:
			begin
				// oscillator kept running, so service without delay
				if (irq_halt_capable_i || rtc_irq_i)
				begin
					next_r.st   = ST_RUN;
					next_r.clk  = CLK_RUN;
					next_r.svc  = 1'b1;
					next_r.push = 1'b1;
					next_r.ilb  = irq_priority_i;
				end
			end
			ST_STAB:
			begin
				if (stab_done)
				begin
					next_r.st  = ST_RUN;
					next_r.clk = CLK_RUN;
					if (r.cause == WK_RESET)
						next_r.fetch = 1'b1;
					else
					begin
						next_r.svc  = 1'b1;
						next_r.push = 1'b1;
						next_r.ilb  = irq_priority_i;
					end
				end
			end
			default:
			begin
				next_r.st  = ST_RUN;
				next_r.clk = CLK_RUN;
			end
		endcase

		next_r.tcap = (r.st == ST_RUN) && autowake_measure_i && r.rc_s2;
		next_r.csr  = 8'h00;
		next_r.csr[`HMPC_CSR_FLAG]    = next_r.awu_flag;
		next_r.csr[`HMPC_CSR_MEASURE] = autowake_measure_i;
		next_r.csr[`HMPC_CSR_ENABLE]  = autowake_enable_i;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			// reset exit also runs the stabilisation delay
			r            <= '0;
			r.st         <= ST_STAB;
			r.cause      <= WK_RESET;
			r.presc      <= `HMPC_PRESC_RST;
			r.ilb        <= `HMPC_ILB_RST;
			r.clk        <= CLK_STAB;
			r.stab_start <= 1'b1;
		end
		else
			r <= next_r;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign clk_en_o                  = r.clk;
	assign mode_o                    = r.st;
	assign interrupt_level_bits_o    = r.ilb;
	assign cc_push_o                 = r.push;
	assign service_irq_o             = r.svc;
	assign fetch_reset_vector_o      = r.fetch;
	assign watchdog_reset_o          = r.wdg_rst;
	assign autowake_irq_o            = r.awu_flag;
	assign autowake_ctrl_status_o    = r.csr;
	assign autowake_prescaler_o      = r.presc;
	assign timer_capture_input_two_o = r.tcap;
endmodule // hmpc_top

// ===== rtl/hmpc_regs.svh
`ifndef HMPC_REGS_SVH
`define HMPC_REGS_SVH

// ----------------------------------------
// instruction decode
// ----------------------------------------
`define HMPC_HALT_OPCODE   8'h8E

// ----------------------------------------
// oscillator stabilisation, cpu cycles
// ----------------------------------------
`define HMPC_STAB_SHORT    13'h0100
`define HMPC_STAB_LONG     13'h1000
`define HMPC_STAB_W        13

// ----------------------------------------
// autowake divider chain
// ----------------------------------------
`define HMPC_AWU_FIXDIV_TC 6'h3F
`define HMPC_PRESC_RST     8'hFF
`define HMPC_PRESC_FORBID  8'h00

// ----------------------------------------
// interrupt level bits forced on halt entry and at reset
// ----------------------------------------
`define HMPC_ILB_HALT      2'h2
`define HMPC_ILB_ACTIVE    2'h0
`define HMPC_ILB_RST       2'h3

// ----------------------------------------
// autowake_ctrl_status fields
// ----------------------------------------
`define HMPC_CSR_FLAG      2
`define HMPC_CSR_MEASURE   1
`define HMPC_CSR_ENABLE    0

`endif

// ===== rtl/hmpc_pkg.sv
package hmpc_pkg;

	// gray along the listed order run, halt, autowake, stab, active
	typedef enum logic [2:0] {
		ST_RUN    = 3'h0,
		ST_HALT   = 3'h1,
		ST_AWU    = 3'h3,
		ST_STAB   = 3'h2,
		ST_ACTIVE = 3'h6
	} hmpc_state_type;

	typedef enum logic [1:0] {
		WK_RESET = 2'h0,
		WK_IRQ   = 2'h1
	} hmpc_cause_type;

	typedef struct packed {
		logic main_osc;
		logic cpu;
		logic periph;
		logic rtc;
		logic wake_rc;
	} hmpc_clk_en_type;

endpackage

// ===== rtl/hmpc_stab_timer.sv
`timescale 1ns/1ps
`include "hmpc_regs.svh"

module hmpc_stab_timer (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic start_i,
	input  wire logic long_i,
	output logic      done_o
);
	import hmpc_pkg::*;

	typedef struct packed {
		logic                     busy;
		logic [`HMPC_STAB_W-1:0]  cnt;
		logic                     done;
	} hmpc_stab_type;

	hmpc_stab_type r;
	hmpc_stab_type next_r;

	always_comb
	begin
		next_r      = r;
		next_r.done = 1'b0;
		if (start_i)
		begin
			next_r.busy = 1'b1;
			next_r.cnt  = long_i ? `HMPC_STAB_LONG - 13'h0001 : `HMPC_STAB_SHORT - 13'h0001;
		end
		else if (r.busy)
		begin
			if (r.cnt == '0)
			begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
			else
				next_r.cnt = r.cnt - 13'h0001;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			r <= '0;
		else
			r <= next_r;
	end

	assign done_o = r.done;
endmodule // hmpc_stab_timer

// ===== rtl/hmpc_awu_timer.sv
`timescale 1ns/1ps
`include "hmpc_regs.svh"

module hmpc_awu_timer (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       run_i,
	input  wire logic       rc_tick_i,
	input  wire logic [7:0] presc_i,
	output logic            done_o
);
	import hmpc_pkg::*;

	typedef struct packed {
		logic [5:0] fix;
		logic [7:0] pre;
		logic       done;
	} hmpc_awu_type;

	hmpc_awu_type r;
	hmpc_awu_type next_r;

	always_comb
	begin
		next_r      = r;
		next_r.done = 1'b0;
		if (!run_i)
		begin
			next_r.fix = 6'h00;
			next_r.pre = 8'h00;
		end
		else if (rc_tick_i)
		begin
			// fixed divide by 64 ahead of the prescaler
			if (r.fix == `HMPC_AWU_FIXDIV_TC)
			begin
				next_r.fix = 6'h00;
				if (r.pre == presc_i - 8'h01)
				begin
					next_r.pre  = 8'h00;
					next_r.done = 1'b1;
				end
				else
					next_r.pre = r.pre + 8'h01;
			end
			else
				next_r.fix = r.fix + 6'h01;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			r <= '0;
		else
			r <= next_r;
	end

	assign done_o = r.done;
endmodule // hmpc_awu_timer

// ===== sim/hmpc_props.sv
`timescale 1ns/1ps
`include "hmpc_regs.svh"

module hmpc_props (
	input logic                      ref_clk_i,
	input logic                      rst_n_i,
	input logic                      instr_valid_i,
	input logic [7:0]                opcode_i,
	input logic                      osc_interrupt_enable_i,
	input logic                      autowake_enable_i,
	input logic                      autowake_prescaler_wr_i,
	input logic [7:0]                autowake_prescaler_wdata_i,
	input logic                      watchdog_enabled_i,
	input logic                      watchdog_halt_option_i,
	input logic                      irq_halt_capable_i,
	input hmpc_pkg::hmpc_clk_en_type clk_en_o,
	input hmpc_pkg::hmpc_state_type  mode_o,
	input logic [1:0]                interrupt_level_bits_o,
	input logic                      service_irq_o,
	input logic                      watchdog_reset_o,
	input logic [7:0]                autowake_prescaler_o
);
	import hmpc_pkg::*;
	// ----------------------------------------
	// halt entry, clocks and wake
	// ----------------------------------------
	logic go;
	logic trip;
	assign go = instr_valid_i && opcode_i == `HMPC_HALT_OPCODE && mode_o == ST_RUN;
	assign trip = watchdog_enabled_i && !watchdog_halt_option_i;
	// cycles spent in the stabilisation state
	logic [12:0] stab_cnt;
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i || mode_o != ST_STAB)
			stab_cnt <= 13'h0000;
		else if (stab_cnt != 13'h1FFF)
			stab_cnt <= stab_cnt + 13'h0001;
	end
	default clocking dc @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_plain_entry:
	assert property (go && !osc_interrupt_enable_i && !autowake_enable_i && !trip |=>
		mode_o == ST_HALT && interrupt_level_bits_o == 2'h2) else $error("plain halt entry");
	a_awu_entry:
	assert property (go && !osc_interrupt_enable_i && autowake_enable_i && !trip |=>
		mode_o == ST_AWU && interrupt_level_bits_o == 2'h2) else $error("autowake entry");
	a_active_entry:
	assert property (go && osc_interrupt_enable_i |=> mode_o == ST_ACTIVE
		&& interrupt_level_bits_o == 2'h0 && !watchdog_reset_o) else $error("active entry");
	a_wdg_trip:
	assert property (go && !osc_interrupt_enable_i && trip |=>
		watchdog_reset_o && mode_o == ST_RUN) else $error("watchdog trip");
	a_halt_clocks:
	assert property (mode_o == ST_HALT |->
		!(clk_en_o.main_osc || clk_en_o.cpu || clk_en_o.periph)) else $error("halt clocks");
	a_active_clocks:
	assert property (mode_o == ST_ACTIVE |-> clk_en_o.main_osc && clk_en_o.rtc
		&& !clk_en_o.cpu && !clk_en_o.periph) else $error("active clocks");
	a_halt_wake:
	assert property ((mode_o == ST_HALT || mode_o == ST_AWU) && irq_halt_capable_i |=>
		mode_o == ST_STAB && clk_en_o.main_osc) else $error("halt wake");
	a_other_hold:
	assert property (mode_o == ST_HALT && !irq_halt_capable_i |=> mode_o == ST_HALT)
		else $error("halt left without cause");
	// counter instead of a long delay range, which the tools unroll
	a_stab_span:
	assert property (mode_o == ST_STAB && stab_cnt < 13'h00FF |=> mode_o == ST_STAB)
		else $error("stabilisation cut short");
	a_stab_bound:
	assert property (stab_cnt <= 13'h1004) else $error("stabilisation too long");
	a_presc_keep:
	assert property (autowake_prescaler_wr_i && autowake_prescaler_wdata_i == 8'h00 |=>
		$stable(autowake_prescaler_o)) else $error("prescaler zero write");
	a_not_halt:
	assert property (instr_valid_i && opcode_i != 8'h8E && mode_o == ST_RUN |=>
		mode_o == ST_RUN) else $error("non halt opcode");
endmodule // hmpc_props

bind hmpc_top hmpc_props i_hmpc_props (.*);

// ===== sim/hmpc_cpu_model.sv
`timescale 1ns/1ps

module hmpc_cpu_model (
	input  logic       ref_clk_i,
	input  logic       rst_n_i,
	input  logic       req_i,
	input  logic [7:0] op_i,
	input  logic       cc_push_i,
	input  logic [1:0] level_i,
	output logic       instr_valid_o,
	output logic [7:0] opcode_o,
	output logic       cc_pop_o,
	output logic [1:0] cc_pop_level_o
);
	// ----------------------------------------
	// core issuing instructions, popping cc
	// ----------------------------------------
	logic [1:0] saved;
	logic [3:0] run;
	always_ff @(posedge ref_clk_i)
	begin
		instr_valid_o <= rst_n_i && req_i;
		// idle bus inverts the opcode every cycle, so a stale one shows every other cycle
		opcode_o <= !rst_n_i ? 8'h00 : (req_i ? op_i : ~opcode_o);
		if (!cc_push_i && run == 4'h0)
			saved <= level_i;
		run <= !rst_n_i ? 4'h0 : (cc_push_i ? 4'h8 : run - {3'h0, run != 4'h0});
		cc_pop_o <= rst_n_i && run == 4'h1;
		cc_pop_level_o <= saved;
	end
endmodule // hmpc_cpu_model

// ===== sim/tb.sv
`timescale 1ns/1ps
`include "hmpc_regs.svh"

module tb;
	import hmpc_pkg::*;
	// ----------------------------------------
	// stimulus, partner and scenarios
	// ----------------------------------------
	logic ref_clk_i = 0, rst_n_i = 0, wake_rc_clock_i = 0, req = 0;
	logic [7:0] op = 8'h00, autowake_prescaler_wdata_i = 8'h00;
	logic osc_interrupt_enable_i = 0, autowake_enable_i = 0, autowake_measure_i = 0;
	logic autowake_ctrl_status_rd_i = 0, autowake_prescaler_wr_i = 0, rtc_irq_i = 0;
	logic watchdog_enabled_i = 0, watchdog_halt_option_i = 0, long_delay_option_i = 0;
	logic irq_halt_capable_i = 0, irq_other_i = 0, instr_valid_i, cc_pop_i;
	logic [1:0] irq_priority_i = 2'h1, cc_pop_level_i, interrupt_level_bits_o;
	logic [7:0] opcode_i, autowake_ctrl_status_o, autowake_prescaler_o;
	logic cc_push_o, service_irq_o, fetch_reset_vector_o, watchdog_reset_o;
	logic autowake_irq_o, timer_capture_input_two_o;
	hmpc_clk_en_type clk_en_o;
	hmpc_state_type mode_o;
	logic [2:0] ev;
	int miscompares = 0, comparisons = 0, n;

	always #4 ref_clk_i = ~ref_clk_i;
	// rc period kept off any multiple of the main clock
	always #20.3 wake_rc_clock_i = ~wake_rc_clock_i;
	assign ev = {service_irq_o, fetch_reset_vector_o, mode_o == ST_STAB};

	hmpc_top i_hmpc_top (.*);
	hmpc_cpu_model i_hmpc_cpu_model (
		.ref_clk_i      (ref_clk_i),
		.rst_n_i        (rst_n_i),
		.req_i          (req),
		.op_i           (op),
		.cc_push_i      (cc_push_o),
		.level_i        (interrupt_level_bits_o),
		.instr_valid_o  (instr_valid_i),
		.opcode_o       (opcode_i),
		.cc_pop_o       (cc_pop_i),
		.cc_pop_level_o (cc_pop_level_i)
	);

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic smp;
		@(negedge ref_clk_i);
	endtask
	task automatic upto(int b);
		n = 0;
		while (ev[b] !== 1'b1 && n < 9000)
		begin
			smp;
			n++;
		end
	endtask
	task automatic halt(logic [7:0] o);
		@(posedge ref_clk_i);
		op <= o;
		req <= 1'b1;
		@(posedge ref_clk_i);
		req <= 1'b0;
		@(posedge ref_clk_i);
		smp;
	endtask
	task automatic wake(int l, logic [1:0] lvl);
		upto(2);
		chk("wake delay", 1, n >= l - 4 && n <= l + 4);
		chk("push", 1, cc_push_o);
		chk("service level", irq_priority_i, interrupt_level_bits_o);
		@(posedge ref_clk_i);
		irq_halt_capable_i <= 1'b0;
		rtc_irq_i <= 1'b0;
		repeat (14) smp;
		chk("restored level", lvl, interrupt_level_bits_o);
	endtask
	task automatic t_halt(logic l);
		@(posedge ref_clk_i);
		{long_delay_option_i, watchdog_enabled_i, watchdog_halt_option_i} <= {l, 2'h3};
		{osc_interrupt_enable_i, autowake_enable_i, irq_other_i} <= 3'h1;
		halt(`HMPC_HALT_OPCODE);
		chk("halt mode", ST_HALT, mode_o);
		chk("halt level", 2'h2, interrupt_level_bits_o);
		chk("halt clocks", 5'h00, clk_en_o);
		repeat (20) smp;
		chk("other irq", ST_HALT, mode_o);
		@(posedge ref_clk_i);
		irq_halt_capable_i <= 1'b1;
		irq_other_i <= 1'b0;
		upto(0);
		chk("osc restart", 1, clk_en_o.main_osc && n <= 2);
		wake(l ? 4096 : 256, 2'h2);
	endtask
	task automatic t_active;
		@(posedge ref_clk_i);
		{osc_interrupt_enable_i, watchdog_enabled_i, watchdog_halt_option_i} <= 3'h6;
		irq_priority_i <= 2'h3;
		halt(`HMPC_HALT_OPCODE);
		chk("active mode", ST_ACTIVE, mode_o);
		chk("active level", 2'h0, interrupt_level_bits_o);
		chk("active wdg", 0, watchdog_reset_o);
		chk("active clocks", 5'h12, clk_en_o);
		repeat (30) smp;
		@(posedge ref_clk_i);
		rtc_irq_i <= 1'b1;
		wake(1, 2'h0);
	endtask
	task automatic t_wdg;
		@(posedge ref_clk_i);
		osc_interrupt_enable_i <= 1'b0;
		halt(8'h8F);
		chk("other opcode", ST_RUN, mode_o);
		halt(`HMPC_HALT_OPCODE);
		chk("wdg reset", 1, watchdog_reset_o);
		chk("wdg mode", ST_RUN, mode_o);
	endtask
	task automatic wr(logic [7:0] d);
		@(posedge ref_clk_i);
		autowake_prescaler_wr_i <= 1'b1;
		autowake_prescaler_wdata_i <= d;
		@(posedge ref_clk_i);
		autowake_prescaler_wr_i <= 1'b0;
		smp;
	endtask
	task automatic t_awu;
		wr(8'h00);
		chk("zero write", 8'hFF, autowake_prescaler_o);
		wr(8'h02);
		chk("prescaler", 8'h02, autowake_prescaler_o);
		@(posedge ref_clk_i);
		{watchdog_enabled_i, autowake_enable_i} <= 2'h1;
		long_delay_option_i <= 1'b0;
		halt(`HMPC_HALT_OPCODE);
		chk("awu mode", ST_AWU, mode_o);
		chk("awu level", 2'h2, interrupt_level_bits_o);
		upto(0);
		chk("awu span", 1, n >= 630 && n <= 670);
		chk("awu flag", 8'h05, autowake_ctrl_status_o);
		chk("awu irq", 1, autowake_irq_o);
		wake(258, 2'h2);
		@(posedge ref_clk_i);
		autowake_ctrl_status_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		autowake_ctrl_status_rd_i <= 1'b0;
		smp;
		chk("read clear", 9'h001, {autowake_irq_o, autowake_ctrl_status_o});
		@(posedge ref_clk_i);
		irq_halt_capable_i <= 1'b1;
		halt(`HMPC_HALT_OPCODE);
		smp;
		chk("pending wake", ST_STAB, mode_o);
		wake(256, 2'h2);
		@(posedge ref_clk_i);
		autowake_enable_i <= 1'b0;
	endtask
	task automatic toggles(output int t);
		logic p;
		t = 0;
		p = timer_capture_input_two_o;
		repeat (200)
		begin
			smp;
			t += int'(timer_capture_input_two_o !== p);
			p = timer_capture_input_two_o;
		end
	endtask
	task automatic t_meas;
		int t;
		@(posedge ref_clk_i);
		autowake_measure_i <= 1'b1;
		toggles(t);
		chk("capture active", 1, t > 20);
		chk("measure osc", 1, clk_en_o.wake_rc);
		@(posedge ref_clk_i);
		autowake_measure_i <= 1'b0;
		repeat (10) smp;
		toggles(t);
		chk("capture idle", 0, t[15:0]);
		chk("measure osc off", 0, clk_en_o.wake_rc);
	endtask
	task automatic test_done;
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (16) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		upto(1);
		chk("reset delay", 1, n >= 255 && n <= 262);
		chk("reset state", 11'h0FF, {mode_o, autowake_prescaler_o});
		t_halt(1'b0);
		t_halt(1'b1);
		t_active();
		t_wdg();
		t_awu();
		t_meas();
		test_done();
	end
	initial
	begin
		#200us;
		miscompares++;
		test_done();
	end
endmodule // tb
